// ==== logic/cps_pkg.sv ====
package cps_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int unsigned WAYS      = 8;
   localparam int unsigned SETS      = 64;
   localparam int unsigned SET_W     = 6;
   localparam int unsigned WAY_W     = 3;
   localparam int unsigned TREE_W    = 7;
   localparam int unsigned LOCK_W    = 3;
   localparam logic [6:0]  TREE_RST  = 7'h00;
   localparam logic [7:0]  VALID_RST = 8'h00;

   // Tree bit positions
   localparam int unsigned T_ROOT = 0;
   localparam int unsigned T_LEFT = 1;
   localparam int unsigned T_RGHT = 2;
   localparam int unsigned T_P01  = 3;
   localparam int unsigned T_P23  = 4;
   localparam int unsigned T_P45  = 5;
   localparam int unsigned T_P67  = 6;

   // Access kinds
   localparam logic [1:0] KIND_FETCH = 2'h0;
   localparam logic [1:0] KIND_LOAD  = 2'h1;
   localparam logic [1:0] KIND_STORE = 2'h2;
   localparam logic [1:0] KIND_ZERO  = 2'h3;

   // Bus transfer sizes
   localparam logic [2:0] BEATS_SINGLE = 3'h1;
   localparam logic [3:0] WORDS_SINGLE = 4'h2;
   localparam logic [2:0] BEATS_BURST  = 3'h4;
   localparam logic [3:0] WORDS_BURST  = 4'h8;

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam int unsigned C_DFI  = 0;
   localparam int unsigned C_IFI  = 1;
   localparam int unsigned C_PRE  = 2;
   localparam int unsigned C_MCE  = 3;
   localparam int unsigned C_FOUR = 4;
   localparam int unsigned S_NREC = 0;
   localparam int unsigned S_IPAR = 10;
   localparam int unsigned S_DPAR = 11;
   localparam logic [4:0]  CTRL_RST   = 5'h00;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage : cps_pkg

// ==== logic/cps_way_select.sv ====
// How it works
// - Hitting valid way selected, tree not consulted
// - Miss with invalid way: lowest invalid way
// - Full unlocked set: victim from tree
// - Seven tree bits kept per set
// - Tree walk picks victim way
// - Four-way mode holds root bit zero
// - Reset clears valid and tree bits
// - Flash invalidate equals reset state
// - Ways 0-3 touched: root set, path marked
// - Ways 4-7 touched: root cleared, path marked
// - Lock count forces tree bits away from locked
// - Tree written on hits and allocations
// - Written value inverts path to used way
// - Written value ignores lock forcing
// - Parity reported only with both enables
// - Parity checked on fetch, load, copy-back
// - Status bit 10 or 11, non-recoverable
// - Single two-word beat or eight-word burst
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cps_way_select (
   input  wire logic                       clk_sys,
   input  wire logic                       arst_n,
   // Access request
   input  wire logic                       req_valid,
   input  wire logic                       req_icache,
   input  wire logic [1:0]                 req_kind,
   input  wire logic [cps_pkg::SET_W-1:0]  req_set,
   input  wire logic [cps_pkg::WAYS-1:0]   req_tag_match,
   input  wire logic                       req_cacheable,
   input  wire logic                       req_par_err,
   input  wire logic [cps_pkg::LOCK_W-1:0] lock_ways,
   input  wire logic                       wb_valid,
   input  wire logic                       wb_par_err,
   // Result
   output logic                            sel_valid_reg,
   output logic                            sel_hit_reg,
   output logic [cps_pkg::WAY_W-1:0]       sel_way_reg,
   output logic [2:0]                      xfer_beats_reg,
   output logic [3:0]                      xfer_words_reg,
   output logic                            mchk_reg,
   // AXI4-Lite
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready
);
   // ------------------------------------------------------------
   // Tree functions
   // ------------------------------------------------------------
   // Lowest set bit of a way mask
   function automatic logic [2:0] cps_lowest(input logic [7:0] m);
      logic [2:0] w;
      w = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) w = i[2:0];
      end
      return w;
   endfunction : cps_lowest

   // Walk the tree to a victim
   function automatic logic [2:0] cps_victim(input logic [6:0] t);
      logic [2:0] w;
      w[2] = t[cps_pkg::T_ROOT];
      if (!t[cps_pkg::T_ROOT]) begin
         w[1] = t[cps_pkg::T_LEFT];
         w[0] = t[cps_pkg::T_LEFT] ? t[cps_pkg::T_P23] : t[cps_pkg::T_P01];
      end else begin
         w[1] = t[cps_pkg::T_RGHT];
         w[0] = t[cps_pkg::T_RGHT] ? t[cps_pkg::T_P67] : t[cps_pkg::T_P45];
      end
      return w;
   endfunction : cps_victim

   // Mark a way most recently used; only its path bits change
   function automatic logic [6:0] cps_touch(input logic [6:0] t,
                                            input logic [2:0] w,
                                            input logic       four);
      logic [6:0] n;
      n = t;
      if (!w[2]) begin
         n[cps_pkg::T_ROOT] = 1'b1;
         n[cps_pkg::T_LEFT] = ~w[1];
         if (!w[1]) n[cps_pkg::T_P01] = ~w[0];
         else n[cps_pkg::T_P23] = ~w[0];
      end else begin
         n[cps_pkg::T_ROOT] = 1'b0;
         n[cps_pkg::T_RGHT] = ~w[1];
         if (!w[1]) n[cps_pkg::T_P45] = ~w[0];
         else n[cps_pkg::T_P67] = ~w[0];
      end
      if (four) n[cps_pkg::T_ROOT] = 1'b0;
      return n;
   endfunction : cps_touch

   // ------------------------------------------------------------
   // State arrays
   // ------------------------------------------------------------
   logic [6:0]  itree_reg [cps_pkg::SETS];
   logic [6:0]  dtree_reg [cps_pkg::SETS];
   logic [7:0]  ivalid_reg [cps_pkg::SETS];
   logic [7:0]  dvalid_reg [cps_pkg::SETS];
   logic [4:0]  ctrl_reg;
   logic [11:0] status_reg;

   // ------------------------------------------------------------
   // Selection
   // ------------------------------------------------------------
   wire logic       four_way   = ctrl_reg[cps_pkg::C_FOUR];
   wire logic [7:0] way_en     = four_way ? 8'h0f : 8'hff;
   wire logic [6:0] tree_rd    = req_icache ? itree_reg[req_set] : dtree_reg[req_set];
   wire logic [7:0] valid_rd   = req_icache ? ivalid_reg[req_set] : dvalid_reg[req_set];
   wire logic [7:0] hit_mask   = req_tag_match & valid_rd & way_en;
   wire logic [7:0] inv_mask   = ~valid_rd & way_en;
   wire logic       hit_any    = |hit_mask;
   wire logic       inv_any    = |inv_mask;
   wire logic [2:0] hit_way    = cps_lowest(hit_mask);
   wire logic [2:0] inv_way    = cps_lowest(inv_mask);
   wire logic [2:0] lock_n     = lock_ways;
   // Force bits away from locked ways, used for the walk only
   wire logic [6:0] tree_lock  = tree_rd | {lock_n >= 3'h7, lock_n >= 3'h5,
                                            lock_n >= 3'h3, lock_n >= 3'h1,
                                            lock_n >= 3'h6, lock_n >= 3'h2,
                                            lock_n >= 3'h4};
   wire logic [6:0] tree_walk  = four_way ? (tree_lock & 7'h7e) : tree_lock;
   wire logic [2:0] victim     = cps_victim(tree_walk);
   wire logic       alloc      = req_valid && !hit_any && req_cacheable;
   // Hit first, then lowest invalid, then tree
   wire logic [2:0] sel_way    = hit_any ? hit_way :
                                 inv_any ? inv_way : victim;
   wire logic       do_update  = req_valid && (hit_any || req_cacheable);
   wire logic [6:0] tree_new   = cps_touch(tree_rd, sel_way, four_way);

   // ------------------------------------------------------------
   // Parity reporting
   // ------------------------------------------------------------
   wire logic ip_err  = req_valid && req_icache && hit_any &&
                        req_kind == cps_pkg::KIND_FETCH && req_par_err;
   wire logic dp_err  = (req_valid && !req_icache && hit_any &&
                         req_kind == cps_pkg::KIND_LOAD && req_par_err) ||
                        (wb_valid && wb_par_err);
   wire logic rep_en  = ctrl_reg[cps_pkg::C_PRE] && ctrl_reg[cps_pkg::C_MCE];
   wire logic ip_rep  = ip_err && rep_en;
   wire logic dp_rep  = dp_err && rep_en;

   // ------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------
   logic       aw_held_reg;
   logic       w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   wire logic  aw_take  = s_axi_awvalid && s_axi_awready;
   wire logic  w_take   = s_axi_wvalid && s_axi_wready;
   wire logic  wr_go    = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire logic  wr_ctrl  = wr_go && aw_addr_reg == cps_pkg::OFS_CTRL;
   wire logic  wr_stat  = wr_go && aw_addr_reg == cps_pkg::OFS_STATUS;
   wire logic [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                              {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire logic [31:0] wval  = w_data_reg & wmask;
   wire logic  flash_d  = wr_ctrl && wval[cps_pkg::C_DFI];
   wire logic  flash_i  = wr_ctrl && wval[cps_pkg::C_IFI];
   wire logic [4:0] ctrl_next = {(ctrl_reg[4:2] & ~wmask[4:2]) | wval[4:2], 2'h0};
   // Write-one-to-clear, a new event wins over the clear
   wire logic [11:0] status_next = (status_reg & ~(wr_stat ? wval[11:0] : 12'h000)) |
                                   (12'h001 & {12{ip_rep || dp_rep}}) |
                                   ({1'b0, ip_rep, 10'h000}) |
                                   ({dp_rep, 11'h000});
   wire logic  ar_take  = s_axi_arvalid && s_axi_arready;
   wire logic  rd_map   = s_axi_araddr == cps_pkg::OFS_CTRL ||
                          s_axi_araddr == cps_pkg::OFS_STATUS;
   wire logic [31:0] rd_val = s_axi_araddr == cps_pkg::OFS_CTRL ?
                              {27'h0000000, ctrl_reg} : {20'h00000, status_reg};

   // ------------------------------------------------------------
   // Tree and valid arrays
   // ------------------------------------------------------------
   // Reset puts every set in the start state, a flash every set of its side; updates are written at the end of the request cycle, seen the cycle after
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int s = 0; s < cps_pkg::SETS; s++) begin
            itree_reg[s]  <= cps_pkg::TREE_RST;
            dtree_reg[s]  <= cps_pkg::TREE_RST;
            ivalid_reg[s] <= cps_pkg::VALID_RST;
            dvalid_reg[s] <= cps_pkg::VALID_RST;
         end
      end else begin
         if (do_update && req_icache) itree_reg[req_set] <= tree_new;
         if (do_update && !req_icache) dtree_reg[req_set] <= tree_new;
         if (alloc && req_icache) ivalid_reg[req_set][sel_way] <= 1'b1;
         if (alloc && !req_icache) dvalid_reg[req_set][sel_way] <= 1'b1;
         for (int s = 0; s < cps_pkg::SETS; s++) begin
            if (flash_i) begin
               itree_reg[s]  <= cps_pkg::TREE_RST;
               ivalid_reg[s] <= cps_pkg::VALID_RST;
            end
            if (flash_d) begin
               dtree_reg[s]  <= cps_pkg::TREE_RST;
               dvalid_reg[s] <= cps_pkg::VALID_RST;
            end
         end
      end
   end

   // Result and transfer size
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sel_valid_reg  <= 1'b0;
         sel_hit_reg    <= 1'b0;
         sel_way_reg    <= 3'h0;
         xfer_beats_reg <= 3'h0;
         xfer_words_reg <= 4'h0;
         mchk_reg       <= 1'b0;
      end else begin
         sel_valid_reg  <= req_valid;
         sel_hit_reg    <= req_valid && hit_any;
         sel_way_reg    <= sel_way;
         xfer_beats_reg <= !req_valid || hit_any ? 3'h0 :
                           req_cacheable ? cps_pkg::BEATS_BURST : cps_pkg::BEATS_SINGLE;
         xfer_words_reg <= !req_valid || hit_any ? 4'h0 :
                           req_cacheable ? cps_pkg::WORDS_BURST : cps_pkg::WORDS_SINGLE;
         mchk_reg       <= ip_rep || dp_rep;
      end
   end

   // Control and status registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg   <= cps_pkg::CTRL_RST;
         status_reg <= 12'h000;
      end else begin
         if (wr_ctrl) ctrl_reg <= ctrl_next;
         status_reg <= status_next;
      end
   end

   // Write channels, address and data in either order
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= cps_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_reg && !aw_take && !s_axi_bvalid;
         s_axi_wready  <= !w_held_reg && !w_take && !s_axi_bvalid;
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ctrl || wr_stat ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLV;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= cps_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_map ? rd_val : 32'h00000000;
            s_axi_rresp  <= rd_map ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLV;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_hit;
      req_valid && hit_any;
   endsequence
   sequence s_miss_inv;
      req_valid && !hit_any && inv_any;
   endsequence
   sequence s_miss_full;
      req_valid && !hit_any && !inv_any;
   endsequence

   AST_HIT_WAY: assert property (s_hit |=> sel_hit_reg && sel_way_reg == $past(hit_way))
      else $error("hit way not selected");
   AST_LOWEST_INV: assert property (s_miss_inv |=> !sel_hit_reg && sel_way_reg == $past(inv_way))
      else $error("lowest invalid way not selected");
   AST_TREE_VICTIM: assert property (s_miss_full |=> sel_way_reg == $past(victim))
      else $error("victim not from tree");
   AST_FOUR_LOW: assert property (req_valid && four_way |=> sel_way_reg[2] == 1'b0)
      else $error("four-way mode picked upper way");
   AST_LOCK_SAFE: assert property (s_miss_full ##0 lock_n != 3'h0 |=>
                                   sel_way_reg >= $past(lock_n))
      else $error("locked way chosen");
   AST_MRU_NOT_NEXT: assert property (do_update && !req_icache && !four_way && !flash_d |=>
                                      cps_victim(dtree_reg[$past(req_set)]) !=
                                      $past(sel_way))
      else $error("touched way is next victim");
   AST_FLASH_D: assert property (flash_d |=> dvalid_reg[0] == 8'h00 && dtree_reg[0] == 7'h00)
      else $error("flash invalidate left state");
   AST_PAR_REPORT: assert property (ip_err && rep_en |=> mchk_reg && status_reg[10] &&
                                    status_reg[0])
      else $error("icache parity not reported");
   AST_PAR_QUIET: assert property (!rep_en |=> !mchk_reg)
      else $error("parity reported while disabled");
   AST_BURST: assert property (alloc |=> xfer_beats_reg == 3'h4 && xfer_words_reg == 4'h8)
      else $error("fill not a four-beat burst");
endmodule : cps_way_select
`default_nettype wire

// ==== tb/cps_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core fetch and load/store side: one access or one idle cycle per call
module cps_core_model (
   output var logic       req_valid,
   output var logic       req_icache,
   output var logic [1:0] req_kind,
   output var logic [5:0] req_set,
   output var logic [7:0] req_tag_match,
   output var logic       req_cacheable,
   output var logic       req_par_err,
   output var logic [2:0] lock_ways,
   output var logic       wb_valid,
   output var logic       wb_par_err
);
   // Quiet lines at time zero
   initial begin
      req_valid = 1'h0;
      req_icache = 1'h0;
      req_kind = 2'h0;
      req_set = 6'h00;
      req_tag_match = 8'h00;
      req_cacheable = 1'h0;
      req_par_err = 1'h0;
      lock_ways = 3'h0;
      wb_valid = 1'h0;
      wb_par_err = 1'h0;
   end
   // Idle cycles invert the qualifiers so stale values are never trusted
   task automatic issue(input logic v, input logic ic, input logic [1:0] kd,
                        input logic [5:0] st, input logic [7:0] mt, input logic ca,
                        input logic pe, input logic [2:0] lk, input logic wv, input logic we);
      req_valid     <= v;
      req_icache    <= v ? ic : ~req_icache;
      req_kind      <= v ? kd : ~req_kind;
      req_set       <= v ? st : ~req_set;
      req_tag_match <= v ? mt : ~req_tag_match;
      req_cacheable <= v ? ca : ~req_cacheable;
      req_par_err   <= v ? pe : ~req_par_err;
      lock_ways     <= lk;
      wb_valid      <= wv;
      wb_par_err    <= we;
   endtask : issue
endmodule : cps_core_model
`default_nettype wire

// ==== tb/test_cache_plru_way_select_parity.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_cache_plru_way_select_parity;
   logic        clk_sys, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, sel_valid_reg, sel_hit_reg, mchk_reg;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, req_tag_match;
   logic [31:0] s_axi_wdata, s_axi_rdata, stat, d;
   logic [3:0]  s_axi_wstrb, xfer_words_reg, p_wd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, req_kind;
   logic [2:0]  sel_way_reg, xfer_beats_reg, lock_ways, p_w, p_b;
   logic [5:0]  req_set;
   logic        req_valid, req_icache, req_cacheable, req_par_err, wb_valid, wb_par_err;
   logic        pre, mce, four, p_v, p_h, p_ca, p_m;
   logic [6:0]  tr [2][64];
   logic [7:0]  vl [2][64];
   int          n_mismatch, check_count, i, m, s;
   logic [31:0] r;
   localparam int ORD [7] = '{3, 1, 4, 0, 5, 2, 6};
   // ------------------------------------------------------------
   // Design, core side and clock
   // ------------------------------------------------------------
   cps_way_select cps_way_select_inst (.clk_sys, .arst_n, .req_valid, .req_icache, .req_kind,
      .req_set, .req_tag_match, .req_cacheable, .req_par_err, .lock_ways, .wb_valid,
      .wb_par_err, .sel_valid_reg, .sel_hit_reg, .sel_way_reg, .xfer_beats_reg,
      .xfer_words_reg, .mchk_reg, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   cps_core_model cps_core_model_inst (.req_valid, .req_icache, .req_kind, .req_set,
      .req_tag_match, .req_cacheable, .req_par_err, .lock_ways, .wb_valid, .wb_par_err);
   // Free-running core clock
   always #20 clk_sys = ~clk_sys;
   // ------------------------------------------------------------
   // Reference model and helpers
   // ------------------------------------------------------------
   // Victim way from a tree walk
   function automatic logic [2:0] pick(input logic [6:0] t);
      if (!t[0]) pick = !t[1] ? {2'h0, t[3]} : {2'h1, t[4]};
      else pick = !t[2] ? {2'h2, t[5]} : {2'h3, t[6]};
   endfunction : pick
   // Locked ways steer the walk away by forcing bits to one
   function automatic logic [6:0] lockf(input logic [6:0] t, input logic [2:0] n);
      for (int k = 0; k < n; k++) t[ORD[k]] = 1'h1;
      lockf = t;
   endfunction : lockf
   // Most-recently-used marking of the path to the way
   function automatic logic [6:0] upd(input logic [6:0] t, input logic [2:0] w, input logic f);
      if (w < 4) begin
         t[0] = 1'h1;
         t[1] = w < 2;
         if (w < 2) t[3] = w == 0;
         else t[4] = w == 2;
      end else begin
         t[0] = 1'h0;
         t[2] = w < 6;
         if (w < 6) t[5] = w == 4;
         else t[6] = w == 6;
      end
      if (f) t[0] = 1'h0;
      upd = t;
   endfunction : upd
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Closing report
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   // One cycle: drive, check the previous access, predict this one
   task automatic step(input logic v, input logic ic, input logic [1:0] kd, input logic [5:0] st,
                       input logic [7:0] mt, input logic ca, input logic pe,
                       input logic [2:0] lk, input logic wv, input logic we);
      logic [7:0] em, vm, hv;
      logic [2:0] w;
      logic       h, rq;
      @(posedge clk_sys);
      cps_core_model_inst.issue(v, ic, kd, st, mt, ca, pe, lk, wv, we);
      #1;
      check(sel_valid_reg, p_v);
      check(sel_hit_reg, p_h);
      if (p_v && (p_h || p_ca)) check(sel_way_reg, p_w);
      check(xfer_beats_reg, p_b);
      check(xfer_words_reg, p_wd);
      check(mchk_reg, p_m);
      em = four ? 8'h0f : 8'hff;
      vm = vl[ic][st] & em;
      hv = mt & vm;
      h = v && hv != 8'h00;
      w = 3'h0;
      if (hv != 8'h00) begin
         for (int k = 7; k >= 0; k--) if (hv[k]) w = k[2:0];
      end else if (vm != em) begin
         for (int k = 7; k >= 0; k--) if (!vm[k] && em[k]) w = k[2:0];
      end else w = pick(lockf(tr[ic][st], lk));
      if (v && (h || ca)) begin
         tr[ic][st] = upd(tr[ic][st], w, four);
         vl[ic][st][w] = 1'h1;
      end
      rq = pre && mce && h && pe && (ic ? kd == cps_pkg::KIND_FETCH : kd == cps_pkg::KIND_LOAD);
      if (rq) stat[ic ? cps_pkg::S_IPAR : cps_pkg::S_DPAR] = 1'h1;
      if (pre && mce && wv && we) stat[cps_pkg::S_DPAR] = 1'h1;
      p_m = rq || (pre && mce && wv && we);
      if (p_m) stat[cps_pkg::S_NREC] = 1'h1;
      {p_v, p_h, p_w, p_ca} = {v, h, w, ca};
      p_b = (!v || h) ? 3'h0 : (ca ? cps_pkg::BEATS_BURST : cps_pkg::BEATS_SINGLE);
      p_wd = (!v || h) ? 4'h0 : (ca ? cps_pkg::WORDS_BURST : cps_pkg::WORDS_SINGLE);
   endtask : step
   // Register write; the model follows control and status writes
   task automatic axw(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
      int k;
      step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, dt, 3'h7};
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            check(s_axi_bresp, er);
            s_axi_bready <= 1'h0;
            break;
         end
      end
      if (k == 50) begin
         n_mismatch++;
         summarize();
      end
      for (int c = 0; c < 2; c++)
         if (a == cps_pkg::OFS_CTRL && dt[c]) begin
            for (int q = 0; q < 64; q++) {tr[c][q], vl[c][q]} = 15'h0000;
         end
      if (a == cps_pkg::OFS_CTRL) {four, mce, pre} = dt[4:2];
      if (a == cps_pkg::OFS_STATUS) stat = stat & ~dt;
   endtask : axw
   // Register read
   task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] dt);
      int k;
      step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      @(posedge clk_sys);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            dt = s_axi_rdata;
            check(s_axi_rresp, er);
            s_axi_rready <= 1'h0;
            break;
         end
      end
      if (k == 50) begin
         n_mismatch++;
         summarize();
      end
   endtask : axr
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {clk_sys, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
      s_axi_wstrb = 4'hf;
      {pre, mce, four, p_v, p_h, p_ca, p_m, p_w, p_b, p_wd, stat} = 49'h0;
      n_mismatch = 0;
      check_count = 0;
      for (s = 0; s < 64; s++) {tr[0][s], vl[0][s], tr[1][s], vl[1][s]} = 30'h0;
      void'($urandom(59239));
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'h1;
      axr(cps_pkg::OFS_CTRL, cps_pkg::RESP_OKAY, d);
      check(d, 32'h0);
      axr(cps_pkg::OFS_STATUS, cps_pkg::RESP_OKAY, d);
      check(d, 32'h0);
      axr(8'h08, cps_pkg::RESP_SLV, d);
      axw(8'h08, 32'h0, cps_pkg::RESP_SLV);
      // Fill the top set back to back, then take victims and a store hit
      for (i = 0; i < 12; i++) step(1, 0, cps_pkg::KIND_LOAD, 6'h3f, 8'h00, 1, 0, 0, 0, 0);
      step(1, 0, cps_pkg::KIND_STORE, 6'h3f, 8'h20, 1, 0, 0, 0, 0);
      step(1, 1, cps_pkg::KIND_FETCH, 6'h01, 8'h00, 1, 0, 0, 0, 0);
      // Flash invalidate of the data side only
      axw(cps_pkg::OFS_CTRL, 32'h1, cps_pkg::RESP_OKAY);
      step(1, 0, cps_pkg::KIND_LOAD, 6'h3f, 8'h20, 1, 0, 0, 0, 0);
      // Parity reporting under every enable combination
      for (i = 0; i < 4; i++) begin
         axw(cps_pkg::OFS_CTRL, i << cps_pkg::C_PRE, cps_pkg::RESP_OKAY);
         step(1, 1, cps_pkg::KIND_FETCH, 6'h01, 8'h01, 1, 1, 0, 0, 0);
         step(1, 0, cps_pkg::KIND_LOAD, 6'h3f, 8'h01, 1, 1, 0, 0, 0);
         step(1, 0, cps_pkg::KIND_STORE, 6'h3f, 8'h01, 1, 1, 0, 0, 0);
         step(0, 0, 0, 0, 0, 0, 0, 0, 1, 1);
         axr(cps_pkg::OFS_STATUS, cps_pkg::RESP_OKAY, d);
         check(d, stat);
         axw(cps_pkg::OFS_STATUS, 32'hc01, cps_pkg::RESP_OKAY);
      end
      // Random traffic, eight ways then four ways with reporting on
      for (m = 0; m < 2; m++) begin
         axw(cps_pkg::OFS_CTRL, m ? 32'h1f : 32'h0, cps_pkg::RESP_OKAY);
         for (i = 0; i < 600; i++) begin
            r = $urandom;
            step(r[0] | r[1], r[2], r[2] ? cps_pkg::KIND_FETCH : (r[4:3] == 2'h0 ? 2'h1 : r[4:3]),
                 {4'h0, r[6:5]}, r[8] ? 8'h01 << r[11:9] : 8'h00, r[12] | r[13], r[14],
                 m ? {1'h0, r[16:15]} : r[17:15], r[18], r[19] & ~r[14]);
         end
      end
      axr(cps_pkg::OFS_STATUS, cps_pkg::RESP_OKAY, d);
      check(d, stat);
      summarize();
   end
endmodule : test_cache_plru_way_select_parity
`default_nettype wire
